// ==== priority_interrupt_arbiter.sv ====
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "intc_cfg.svh"
// How it works
// - 45 sources: 9 CPU traps, 26 peripherals, 10 external pins.
// - Each source has a fixed service vector, four times its index; its micro DMA vector is the index.
// - Maskable sources hold a software level, usable values 1 to 6.
// - Non-maskable sources always present level 7.
// - Only the highest pending level is forwarded to the core.
// - Core accepts when forwarded level is at least the mask.
// - Mask-load instruction writes its operand into the mask.
// - Mask-all instruction loads mask with 7.
// - New mask value governs acceptance from the next cycle.
// - Accepted request may start a micro DMA of 1, 2 or 4 bytes.
// - Software may start a micro DMA transfer directly.
// - On general-service acceptance mask becomes level plus one, capped at 7; a micro DMA acceptance leaves it.
// - Reset sets mask to 7.
// - Equal levels resolve toward the smaller vector.
// - Service address is vector base plus vector.
module priority_interrupt_arbiter
    import intc_pkg::*;
#(
    parameter int N_CPU = 9,
    parameter int N_EXT = 10,
    parameter int N_PERIPH = 26
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [N_CPU-1:0] cpu_trap_req,
    input wire logic nmi_pin,
    input wire logic [N_EXT-2:0] external_request_pins,
    input wire logic [N_PERIPH-1:0] periph_req,
    input wire logic core_ready,
    input wire logic mask_load_instruction,
    input wire logic [2:0] mask_load_value,
    input wire logic mask_all_instruction,
    output logic [2:0] cpu_priority_mask,
    output logic pending_valid,
    output logic [2:0] pending_level,
    output logic int_accept,
    output service_t int_service,
    output logic udma_start,
    output logic [7:0] udma_vector,
    output dma_size_t udma_size,
    output logic irq
);

    localparam int N_SRC = N_CPU + N_EXT + N_PERIPH;
    localparam int N_NONMASK = N_CPU + 1;
    localparam int N_HI = N_SRC - 32;

    // Byte-lane merge for read-write registers
    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Level that takes part in arbitration
    function automatic logic [2:0] eff_level(int idx, logic [2:0] lv);
        if (idx < N_NONMASK) begin
            return `LEVEL_TOP;
        end
        if (lv == `LEVEL_OFF || lv == `LEVEL_TOP) begin
            return `LEVEL_OFF;
        end
        return lv;
    endfunction

    logic aw_held, w_held, do_write, swdma_pend;
    logic [7:0] aw_addr;
    logic [7:0] sw_vector;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [2:0] level [N_SRC];
    logic [3*N_SRC-1:0] eff_flat;
    logic [N_SRC-1:0] src, src_prev, pending, dma_sel, clr;
    logic [2:0] status, enable, next_mask;
    logic [1:0] size_reg;
    logic accept_now, dma_route, hw_dma, sw_issue, set_general;
    logic [31:0] rd_word;
    logic rd_ok;
    grant_t best;

    assign src = {periph_req, external_request_pins, nmi_pin, cpu_trap_req};

    // Write channel handshakes, address and data taken in either order
    assign awready = !aw_held;
    assign wready = !w_held;
    assign do_write = aw_held && w_held && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= (aw_addr[1:0] == 2'h0 && (aw_addr <= `OFF_LEVEL_LAST
                      || aw_addr <= `OFF_LAST && aw_addr >= `OFF_DMASEL0))
                      ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Per-source levels, non-maskable fields ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N_SRC; i++) begin
                level[i] <= `LEVEL_OFF;
            end
        end else if (do_write && aw_addr <= `OFF_LEVEL_LAST && aw_addr[1:0] == 2'h0) begin
            for (int k = 0; k < 8; k++) begin
                if (8 * int'(aw_addr[4:2]) + k >= N_NONMASK && 8 * int'(aw_addr[4:2]) + k < N_SRC
                    && w_strb[k/2]) begin
                    level[8 * int'(aw_addr[4:2]) + k] <= w_data[4*k +: 3];
                end
            end
        end
    end

    // Flattened effective levels for the resolver
    always_comb begin
        eff_flat = '0;
        for (int i = 0; i < N_SRC; i++) begin
            eff_flat[3*i +: 3] = eff_level(i, level[i]);
        end
    end

    // Micro DMA routing, size and enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_sel <= '0;
            size_reg <= 2'h0;
            enable <= 3'h0;
        end else if (do_write) begin
            unique case (aw_addr)
                `OFF_DMASEL0: dma_sel[31:0] <= merge(dma_sel[31:0], w_data, w_strb);
                `OFF_DMASEL1: dma_sel[N_SRC-1:32] <= N_HI'(merge(32'(dma_sel[N_SRC-1:32]),
                    w_data, w_strb));
                `OFF_DMASIZE: size_reg <= w_strb[0] && w_data[1:0] != 2'h3 ? w_data[1:0] : size_reg;
                `OFF_ENABLE: enable <= w_strb[0] ? w_data[2:0] : enable;
                default: ;
            endcase
        end
    end

    // Edge capture of requests; a new edge beats the acceptance clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev <= '0;
            pending <= '0;
        end else begin
            src_prev <= src;
            pending <= (pending & ~clr) | (src & ~src_prev);
        end
    end

    priority_resolver #(
        .N(N_SRC)
    ) u_resolver (
        .pending(pending),
        .levels(eff_flat),
        .best(best)
    );

    // Forwarded request and acceptance decision
    assign pending_valid = best.valid;
    assign pending_level = best.level;
    assign accept_now = best.valid && best.level >= cpu_priority_mask && core_ready
                        && !mask_load_instruction && !mask_all_instruction;
    assign dma_route = dma_sel[best.index] && int'(best.index) >= N_NONMASK;
    assign hw_dma = accept_now && dma_route;
    assign sw_issue = swdma_pend && !hw_dma;
    assign set_general = accept_now && !dma_route;
    assign clr = accept_now ? N_SRC'(1) << best.index : '0;
    assign next_mask = best.level == `LEVEL_TOP ? `LEVEL_TOP : best.level + 3'h1;

    // Priority mask of the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_priority_mask <= `MASK_RESET;
        end else if (mask_all_instruction) begin
            cpu_priority_mask <= `LEVEL_TOP;
        end else if (mask_load_instruction) begin
            cpu_priority_mask <= mask_load_value;
        end else if (set_general) begin
            cpu_priority_mask <= next_mask;
        end else if (do_write && aw_addr == `OFF_MASK && w_strb[0]) begin
            cpu_priority_mask <= w_data[2:0];
        end
    end

    // General service hand-off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_accept <= 1'b0;
            int_service <= '0;
        end else begin
            int_accept <= set_general;
            if (set_general) begin
                int_service.level <= best.level;
                int_service.vector <= {best.index, 2'b00};
                int_service.vaddr <= `VECTOR_BASE + {16'h0, best.index, 2'b00};
            end
        end
    end

    // Software start waits while a hardware transfer takes the port; its vector is kept apart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swdma_pend <= 1'b0;
            sw_vector <= 8'h00;
            udma_start <= 1'b0;
            udma_vector <= 8'h00;
            udma_size <= SIZE_1;
        end else begin
            udma_start <= hw_dma || sw_issue;
            if (do_write && aw_addr == `OFF_SWDMA && w_strb[0]) begin
                swdma_pend <= 1'b1;
                sw_vector <= w_data[7:0];
            end else if (sw_issue) begin
                swdma_pend <= 1'b0;
            end
            if (hw_dma) begin
                udma_vector <= {2'b00, best.index};
            end else if (sw_issue) begin
                udma_vector <= sw_vector;
            end
            if (hw_dma || sw_issue) begin
                udma_size <= dma_size_t'(size_reg);
            end
        end
    end

    // Sticky events; a new event beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= 3'h0;
        end else begin
            status <= (status & ~((do_write && aw_addr == `OFF_CLEAR && w_strb[0])
                      ? w_data[2:0] : 3'h0))
                      | {sw_issue, hw_dma, set_general};
        end
    end

    assign irq = |(status & enable);

    // Read decode
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        if (araddr <= `OFF_LEVEL_LAST && araddr[1:0] == 2'h0) begin
            for (int k = 0; k < 8; k++) begin
                if (8 * int'(araddr[4:2]) + k < N_SRC) begin
                    rd_word[4*k +: 3] = 8 * int'(araddr[4:2]) + k < N_NONMASK ? `LEVEL_TOP
                                        : level[8 * int'(araddr[4:2]) + k];
                end
            end
        end else begin
            unique case (araddr)
                `OFF_DMASEL0: rd_word = dma_sel[31:0];
                `OFF_DMASEL1: rd_word = 32'(dma_sel[N_SRC-1:32]);
                `OFF_DMASIZE: rd_word = {30'h0, size_reg};
                `OFF_MASK: rd_word = {29'h0, cpu_priority_mask};
                `OFF_SWDMA: rd_word = {23'h0, swdma_pend, sw_vector};
                `OFF_PEND0: rd_word = pending[31:0];
                `OFF_PEND1: rd_word = 32'(pending[N_SRC-1:32]);
                `OFF_STATUS: rd_word = {29'h0, status};
                `OFF_CLEAR: rd_word = 32'h0;
                `OFF_ENABLE: rd_word = {29'h0, enable};
                `OFF_LAST: rd_word = {8'h0, int_service.level, 5'h0, int_service.vector, 8'h0};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // Read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks
    logic better_exists;
    always_comb begin
        better_exists = 1'b0;
        for (int j = 0; j < N_SRC; j++) begin
            if (pending[j] && eff_flat[3*j +: 3] != 3'h0 && best.valid
                && (eff_flat[3*j +: 3] > best.level
                    || (eff_flat[3*j +: 3] == best.level && j < int'(best.index)))) begin
                better_exists = 1'b1;
            end
        end
    end

    property p_mask_reset;
        @(posedge aclk) $rose(aresetn) |-> cpu_priority_mask == 3'h7;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not 7 after reset");

    property p_accept_level;
        @(posedge aclk) disable iff (!aresetn)
        int_accept |-> $past(best.level) >= $past(cpu_priority_mask);
    endproperty
    a_accept_level: assert property (p_accept_level) else $error("accepted below mask");

    property p_mask_raise;
        @(posedge aclk) disable iff (!aresetn)
        int_accept |-> cpu_priority_mask == (int_service.level == 3'h7 ? 3'h7
                                             : int_service.level + 3'h1);
    endproperty
    a_mask_raise: assert property (p_mask_raise) else $error("mask not raised");

    property p_mask_load;
        @(posedge aclk) disable iff (!aresetn)
        mask_load_instruction && !mask_all_instruction |=>
            cpu_priority_mask == $past(mask_load_value) && !int_accept;
    endproperty
    a_mask_load: assert property (p_mask_load) else $error("mask load lost");

    property p_mask_all;
        @(posedge aclk) disable iff (!aresetn)
        mask_all_instruction |=> cpu_priority_mask == 3'h7;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("mask-all did not give 7");

    property p_vector;
        @(posedge aclk) disable iff (!aresetn)
        int_accept |-> int_service.vector == {$past(best.index), 2'b00}
            && int_service.vaddr == 24'hffff00 + {16'h0, int_service.vector};
    endproperty
    a_vector: assert property (p_vector) else $error("vector or address wrong");

    property p_nonmask;
        @(posedge aclk) disable iff (!aresetn)
        best.valid && int'(best.index) < N_NONMASK |-> best.level == 3'h7;
    endproperty
    a_nonmask: assert property (p_nonmask) else $error("non-maskable level not 7");

    property p_winner;
        @(posedge aclk) disable iff (!aresetn)
        best.valid |-> !better_exists;
    endproperty
    a_winner: assert property (p_winner) else $error("wrong arbitration winner");

    property p_hw_dma;
        @(posedge aclk) disable iff (!aresetn)
        hw_dma |=> udma_start && !int_accept && udma_vector == {2'b00, $past(best.index)};
    endproperty
    a_hw_dma: assert property (p_hw_dma) else $error("micro DMA not started");

    property p_sw_dma;
        @(posedge aclk) disable iff (!aresetn)
        do_write && aw_addr == 8'h30 && w_strb[0] |-> ##[1:3] udma_start;
    endproperty
    a_sw_dma: assert property (p_sw_dma) else $error("software DMA start lost");

endmodule

// ==== intc_cfg.svh ====
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH

// Register byte offsets
`define OFF_LEVEL0 8'h00
`define OFF_LEVEL_LAST 8'h14
`define OFF_DMASEL0 8'h20
`define OFF_DMASEL1 8'h24
`define OFF_DMASIZE 8'h28
`define OFF_MASK 8'h2c
`define OFF_SWDMA 8'h30
`define OFF_PEND0 8'h34
`define OFF_PEND1 8'h38
`define OFF_STATUS 8'h3c
`define OFF_CLEAR 8'h40
`define OFF_ENABLE 8'h44
`define OFF_LAST 8'h48

// Reset values and fixed levels
`define MASK_RESET 3'h7
`define LEVEL_TOP 3'h7
`define LEVEL_OFF 3'h0
`define VECTOR_BASE 24'hffff00

// Status bit positions
`define ST_GENERAL 0
`define ST_HWDMA 1
`define ST_SWDMA 2

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== intc_pkg.sv ====
package intc_pkg;

    // Winner of arbitration
    typedef struct packed {
        logic valid;
        logic [2:0] level;
        logic [5:0] index;
    } grant_t;

    // Service request handed to the core
    typedef struct packed {
        logic [2:0] level;
        logic [7:0] vector;
        logic [23:0] vaddr;
    } service_t;

    typedef enum logic [1:0] {
        SIZE_1,
        SIZE_2,
        SIZE_4
    } dma_size_t;

endpackage

// ==== priority_resolver.sv ====
`timescale 1ns/1ps
module priority_resolver
    import intc_pkg::*;
#(
    parameter int N = 45
) (
    input wire logic [N-1:0] pending,
    input wire logic [3*N-1:0] levels,
    output grant_t best
);

    // Highest level wins; downward scan lets the smaller index win ties
    always_comb begin
        best = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i] && levels[3*i +: 3] != 3'h0 && levels[3*i +: 3] >= best.level) begin
                best.valid = 1'b1;
                best.level = levels[3*i +: 3];
                best.index = 6'(i);
            end
        end
    end

endmodule

// ==== core_model.sv ====
`timescale 1ns/1ps
module core_model
    import intc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic int_accept,
    input wire service_t int_service,
    input wire logic udma_start,
    output logic core_ready = 1'b0,
    output logic mask_load_instruction = 1'b0,
    output logic [2:0] mask_load_value = 3'h0,
    output logic mask_all_instruction = 1'b0
);
    int n_acc;
    int n_dma;
    service_t last_svc;
    logic [15:0] lfsr;

    // Count services, keep the last vector, stall at random when slow
    always @(posedge aclk) begin
        if (!aresetn) begin
            n_acc <= 0;
            n_dma <= 0;
            lfsr <= 16'h0001;
            core_ready <= 1'b0;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            core_ready <= !slow || lfsr[0];
            if (int_accept) begin
                n_acc <= n_acc + 1;
                last_svc <= int_service;
            end
            if (udma_start) begin
                n_dma <= n_dma + 1;
            end
        end
    end

    // Mask-load instruction, one cycle wide
    task automatic load_mask(input logic [2:0] v);
        @(posedge aclk);
        mask_load_instruction <= 1'b1;
        mask_load_value <= v;
        @(posedge aclk);
        mask_load_instruction <= 1'b0;
        @(negedge aclk);
    endtask

    // Mask-all instruction, one cycle wide
    task automatic mask_all();
        @(posedge aclk);
        mask_all_instruction <= 1'b1;
        @(posedge aclk);
        mask_all_instruction <= 1'b0;
        @(negedge aclk);
    endtask
endmodule

// ==== priority_interrupt_arbiter_tb_top.sv ====
`timescale 1ns/1ps
`include "intc_cfg.svh"
module priority_interrupt_arbiter_tb_top
    import intc_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd, tmp;
    logic [31:0] seed = 32'd39398;
    logic [3:0] wstrb;
    logic [44:0] src;
    logic [1:0] rs, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, irq, pending_valid, int_accept;
    logic udma_start, core_ready, mask_load_instruction, mask_all_instruction;
    logic [31:0] rdata;
    logic [2:0] cpu_priority_mask, pending_level, mask_load_value, lvl, m, la, lb;
    logic [7:0] udma_vector;
    service_t int_service;
    dma_size_t udma_size;
    bit got, ok;
    int idx, a, b, base;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int nmis[3] = '{0, 8, 9};

    priority_interrupt_arbiter u_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .cpu_trap_req(src[8:0]), .nmi_pin(src[9]),
        .external_request_pins(src[18:10]), .periph_req(src[44:19]), .core_ready,
        .mask_load_instruction, .mask_load_value, .mask_all_instruction,
        .cpu_priority_mask, .pending_valid, .pending_level, .int_accept, .int_service,
        .udma_start, .udma_vector, .udma_size, .irq
    );

    core_model u_core (
        .aclk, .aresetn, .slow, .int_accept, .int_service, .udma_start, .core_ready,
        .mask_load_instruction, .mask_load_value, .mask_all_instruction
    );

    // Clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected service record of a source
    function automatic service_t exp_svc(input int i, input logic [2:0] l);
        return {l, 8'(4 * i), 24'hffff00 + 24'(4 * i)};
    endfunction

    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    // Level word of a source, other fields of the word disabled
    task automatic set_level(input int i, input logic [2:0] l);
        axi_wr(8'(4 * (i / 8)), 32'(l) << (4 * (i % 8)), rs);
    endtask

    task automatic raise(input logic [44:0] msk);
        @(posedge aclk);
        src <= msk;
        @(posedge aclk);
        src <= '0;
    endtask

    // Bounded wait for the core to see a service or a transfer
    task automatic wait_evt(input bit dma, input int start, output bit g);
        int t;
        g = 1'b0;
        t = 0;
        while (!g && t < 40) begin
            @(posedge aclk);
            t++;
            g = (dma ? u_core.n_dma : u_core.n_acc) != start;
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
        {awaddr, araddr, wdata, src} = '0;
        wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(cpu_priority_mask, `MASK_RESET);
        check(irq, 1'b0);
        axi_rd(`OFF_LEVEL0, rd, rs);
        check(rd[2:0], `LEVEL_TOP);
        axi_wr(`OFF_ENABLE, 32'h7, rs);
        // Non-maskable sources pass a closed mask
        foreach (nmis[k]) begin
            raise(45'd1 << nmis[k]);
            wait_evt(1'b0, u_core.n_acc, got);
            check(u_core.last_svc, exp_svc(nmis[k], 3'h7));
            check(cpu_priority_mask, 3'h7);
            check(irq, 1'b1);
            axi_rd(`OFF_STATUS, rd, rs);
            check(rd[`ST_GENERAL], 1'b1);
            axi_wr(`OFF_CLEAR, 32'h7, rs);
            check(irq, 1'b0);
        end
        // Random levels, masks and core stalls
        repeat (12) begin
            tmp = rnd();
            lvl = tmp[2:0];
            m = tmp[5:3];
            slow <= tmp[6];
            idx = 10 + int'(tmp[31:8] % 35);
            u_core.mask_all();
            check(cpu_priority_mask, 3'h7);
            set_level(idx, lvl);
            raise(45'd1 << idx);
            repeat (2) @(posedge aclk);
            ok = lvl inside {[3'h1:3'h6]};
            check(pending_valid, ok);
            if (ok) check(pending_level, lvl);
            u_core.load_mask(m);
            check(cpu_priority_mask, m);
            wait_evt(1'b0, u_core.n_acc, got);
            check(got, ok && lvl >= m);
            if (got) begin
                check(u_core.last_svc, exp_svc(idx, lvl));
                check(cpu_priority_mask, lvl + 3'h1);
            end else if (ok) begin
                u_core.load_mask(3'h0);
                wait_evt(1'b0, u_core.n_acc, got);
                check(got, 1'b1);
            end
            set_level(idx, 3'h0);
        end
        // Two requests at once, ties on some rounds
        repeat (4) begin
            tmp = rnd();
            a = 16 + int'(tmp[2:0]);
            b = 24 + int'(tmp[5:3]);
            la = 3'h1 + tmp[10:8] % 3'h6;
            lb = tmp[6] ? la : 3'h1 + tmp[13:11] % 3'h6;
            u_core.mask_all();
            set_level(a, la);
            set_level(b, lb);
            raise((45'd1 << a) | (45'd1 << b));
            u_core.load_mask(3'h0);
            wait_evt(1'b0, u_core.n_acc, got);
            check(u_core.last_svc, lb > la ? exp_svc(b, lb) : exp_svc(a, la));
            u_core.load_mask(3'h0);
            wait_evt(1'b0, u_core.n_acc, got);
            check(u_core.last_svc, lb > la ? exp_svc(a, la) : exp_svc(b, lb));
            set_level(a, 3'h0);
            set_level(b, 3'h0);
        end
        // Request routed to micro DMA, every size
        for (int sz = 0; sz < 3; sz++) begin
            axi_wr(`OFF_DMASIZE, 32'(sz), rs);
            axi_wr(`OFF_DMASEL0, 32'h1 << 20, rs);
            set_level(20, 3'h3);
            u_core.load_mask(3'h0);
            raise(45'd1 << 20);
            wait_evt(1'b1, u_core.n_dma, got);
            check(udma_vector, 8'd20);
            check(udma_size, sz);
            check(cpu_priority_mask, 3'h0);
        end
        check(irq, 1'b1);
        axi_wr(`OFF_DMASEL0, 32'h0, rs);
        set_level(20, 3'h0);
        // Software start with its status bit not enabled
        axi_wr(`OFF_CLEAR, 32'h7, rs);
        axi_wr(`OFF_ENABLE, 32'h3, rs);
        tmp = rnd();
        base = u_core.n_dma;
        axi_wr(`OFF_SWDMA, {24'h0, tmp[7:0]}, rs);
        wait_evt(1'b1, base, got);
        check(udma_vector, tmp[7:0]);
        check(irq, 1'b0);
        axi_rd(`OFF_STATUS, rd, rs);
        check(rd[`ST_SWDMA], 1'b1);
        // Unmapped and unaligned places
        axi_rd(8'h4c, rd, rs);
        check({rs, rd}, {`RESP_SLVERR, 32'h0});
        axi_wr(8'h4c, 32'h0, rs);
        check(rs, `RESP_SLVERR);
        axi_wr(8'h12, 32'h3333, rs);
        check(rs, `RESP_SLVERR);
        axi_rd(8'h10, rd, rs);
        check(rd, 32'h0);
        // Size code 3 is refused, mask also writable by software
        axi_wr(`OFF_DMASIZE, 32'h3, rs);
        axi_rd(`OFF_DMASIZE, rd, rs);
        check(rd[1:0], 2'h2);
        axi_wr(`OFF_MASK, 32'h5, rs);
        axi_rd(`OFF_MASK, rd, rs);
        check(rd[2:0], 3'h5);
        final_report();
    end
endmodule
